/* design/lpis_pkg.sv */
// shared types and constants for the lpddr4 init sequencer
package lpis_pkg;

	localparam int MR_AW = 6;
	localparam int MR_DW = 8;
	localparam int N_BANK = 8;
	localparam int N_MR = 7;

	// mode register numbers held by the device
	localparam logic [5:0] MR1_ADDR = 6'h01;
	localparam logic [5:0] MR2_ADDR = 6'h02;
	localparam logic [5:0] MR3_ADDR = 6'h03;
	localparam logic [5:0] MR11_ADDR = 6'h0B;
	localparam logic [5:0] MR12_ADDR = 6'h0C;
	localparam logic [5:0] MR13_ADDR = 6'h0D;
	localparam logic [5:0] MR14_ADDR = 6'h0E;

	// power-up defaults
	localparam logic [7:0] MR1_RST = 8'h00;
	localparam logic [7:0] MR2_RST = 8'h00;
	localparam logic [7:0] MR3_RST = 8'h00;
	localparam logic [7:0] MR11_RST = 8'h00;
	localparam logic [7:0] MR12_RST = 8'h5D;
	localparam logic [7:0] MR13_RST = 8'h00;
	localparam logic [7:0] MR14_RST = 8'h5D;

	// field positions
	localparam int MR1_NWR_LSB = 4;
	localparam int MR2_WLEV_BIT = 7;
	localparam int MR2_WLS_BIT = 6;
	localparam int MR2_WL_LSB = 3;
	localparam int MR2_RL_LSB = 0;
	localparam int MR3_DBI_LSB = 6;
	localparam int MR11_CAODT_LSB = 4;
	localparam int MR11_DQODT_LSB = 0;
	localparam int VREF_RANGE_BIT = 6;
	localparam int VREF_VAL_LSB = 0;
	localparam int MR13_FSP_LSB = 6;
	localparam int MR13_CBT_BIT = 0;

	localparam logic [5:0] MR_ADDRS [N_MR] = '{MR1_ADDR, MR2_ADDR, MR3_ADDR, MR11_ADDR,
		MR12_ADDR, MR13_ADDR, MR14_ADDR};
	localparam logic [7:0] MR_RSTS [N_MR] = '{MR1_RST, MR2_RST, MR3_RST, MR11_RST,
		MR12_RST, MR13_RST, MR14_RST};
	// software may read these back; the rest are write-only
	localparam logic MR_READABLE [N_MR] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

	localparam logic [15:0] DQ_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_PRE,
		CMD_PRE_ALL,
		CMD_REF,
		CMD_SRE,
		CMD_SRX,
		CMD_MPC,
		CMD_MPC_DONE
	} lpis_cmd_e;

	typedef struct packed {
		logic      valid;
		lpis_cmd_e code;
		logic [2:0] bank;
		logic [5:0] ca;
	} lpis_cmd_s;

	typedef enum logic [3:0] {
		ST_RESET,
		ST_IDLE,
		ST_ACTIVE,
		ST_MRW,
		ST_MRR,
		ST_MPC,
		ST_SREF,
		ST_PDN,
		ST_SREF_PDN,
		ST_CBT,
		ST_WLEV
	} lpis_state_e;

	typedef struct packed {
		logic [1:0] freq_set_point_select;
		logic       write_latency_set_bit;
		logic [2:0] wl_code;
		logic [2:0] rl_code;
		logic [2:0] write_recovery_cycles;
		logic [1:0] dbi_en;
		logic [2:0] ca_odt;
		logic [2:0] dq_odt;
		logic       vref_ca_range;
		logic [5:0] vref_ca_value;
		logic       vref_dq_range;
		logic [5:0] vref_dq_value;
	} lpis_cfg_s;

endpackage

/* design/lpis_mr_reg.sv */
// one mode register with its power-up default
`timescale 1ns/1ps
module lpis_mr_reg #(
	parameter logic [5:0] ADDR    = 6'h00,
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       wr_en,
	input  wire logic [5:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] value_q
);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			value_q <= RST_VAL;
		end else if (wr_en && addr == ADDR) begin
			value_q <= wdata;
		end
	end

endmodule

/* design/lpis_init_sequencer.sv */
// device-side state tracking and mode register defaults for lpddr4 bring-up
`timescale 1ns/1ps
module lpis_init_sequencer (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  cke,
	input  wire logic                  cs,
	input  wire lpis_pkg::lpis_cmd_s   cmd,
	input  wire logic [5:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	output lpis_pkg::lpis_state_e      state,
	output logic      [7:0]            banks_open,
	output logic      [15:0]           dq_out,
	output logic                       dq_oe,
	output lpis_pkg::lpis_cfg_s        cfg
);

	lpis_pkg::lpis_state_e state_q;
	lpis_pkg::lpis_state_e state_d;
	lpis_pkg::lpis_state_e ret_q;
	logic [7:0]            banks_q;
	logic [7:0]            banks_d;
	logic                  cke_q;
	logic [7:0]            rdata_q;
	logic [15:0]           dq_q;
	logic                  dq_oe_q;
	logic                  mr_wr_ok;
	logic                  mr_rd_ok;
	logic [7:0]            mr_val [lpis_pkg::N_MR];
	logic [7:0]            mr2_new;
	logic [7:0]            mr13_new;

	// mode access is refused while in reset or any power-down
	always_comb begin
		mr_wr_ok = 1'b0;
		mr_rd_ok = 1'b0;
		case (state_q)
			lpis_pkg::ST_IDLE, lpis_pkg::ST_ACTIVE, lpis_pkg::ST_SREF,
			lpis_pkg::ST_CBT, lpis_pkg::ST_WLEV: begin
				mr_wr_ok = reg_wr;
				mr_rd_ok = reg_rd;
			end
			default: begin
				mr_wr_ok = 1'b0;
				mr_rd_ok = 1'b0;
			end
		endcase
	end

	for (genvar i = 0; i < lpis_pkg::N_MR; i++) begin : g_mr
		lpis_mr_reg #(
			.ADDR    (lpis_pkg::MR_ADDRS[i]),
			.RST_VAL (lpis_pkg::MR_RSTS[i])
		) u_mr (
			.clk_sys (clk_sys),
			.rstn    (rstn),
			.wr_en   (mr_wr_ok),
			.addr    (reg_addr),
			.wdata   (reg_wdata),
			.value_q (mr_val[i])
		);
	end

	assign mr2_new = reg_wdata;
	assign mr13_new = reg_wdata;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cke_q <= 1'b0;
		end else begin
			cke_q <= cke;
		end
	end

	always_comb begin
		banks_d = banks_q;
		if (cmd.valid) begin
			case (cmd.code)
				lpis_pkg::CMD_ACT: begin
					if (state_q == lpis_pkg::ST_IDLE || state_q == lpis_pkg::ST_ACTIVE) begin
						banks_d[cmd.bank] = 1'b1;
					end
				end
				lpis_pkg::CMD_PRE: banks_d[cmd.bank] = 1'b0;
				lpis_pkg::CMD_PRE_ALL: banks_d = lpis_pkg::BYTE_ZERO;
				default: banks_d = banks_q;
			endcase
		end
		if (state_q == lpis_pkg::ST_RESET) begin
			banks_d = lpis_pkg::BYTE_ZERO;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			banks_q <= lpis_pkg::BYTE_ZERO;
		end else begin
			banks_q <= banks_d;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			lpis_pkg::ST_RESET: begin
				// first clock enable rise must come with cs low
				if (cke && !cke_q && !cs) begin
					state_d = lpis_pkg::ST_IDLE;
				end
			end
			lpis_pkg::ST_IDLE, lpis_pkg::ST_ACTIVE: begin
				if (mr_wr_ok) begin
					state_d = lpis_pkg::ST_MRW;
				end else if (mr_rd_ok) begin
					state_d = lpis_pkg::ST_MRR;
				end else if (!cke) begin
					state_d = lpis_pkg::ST_PDN;
				end else if (cmd.valid && cmd.code == lpis_pkg::CMD_SRE
					&& state_q == lpis_pkg::ST_IDLE && banks_q == lpis_pkg::BYTE_ZERO) begin
					state_d = lpis_pkg::ST_SREF;
				end else if (cmd.valid && cmd.code == lpis_pkg::CMD_MPC
					&& state_q == lpis_pkg::ST_IDLE) begin
					state_d = lpis_pkg::ST_MPC;
				end else if (banks_d != lpis_pkg::BYTE_ZERO) begin
					state_d = lpis_pkg::ST_ACTIVE;
				end else begin
					state_d = lpis_pkg::ST_IDLE;
				end
			end
			lpis_pkg::ST_MRW: begin
				// training entry stays put rather than returning
				if (ret_q != lpis_pkg::ST_SREF && mr_val[5][lpis_pkg::MR13_CBT_BIT]) begin
					state_d = lpis_pkg::ST_CBT;
				end else if (ret_q != lpis_pkg::ST_SREF
					&& mr_val[1][lpis_pkg::MR2_WLEV_BIT]) begin
					state_d = lpis_pkg::ST_WLEV;
				end else begin
					state_d = ret_q;
				end
			end
			lpis_pkg::ST_MRR: state_d = ret_q;
			lpis_pkg::ST_MPC: begin
				if (cmd.valid && cmd.code == lpis_pkg::CMD_MPC_DONE) begin
					state_d = ret_q;
				end
			end
			lpis_pkg::ST_SREF: begin
				if (mr_wr_ok) begin
					state_d = lpis_pkg::ST_MRW;
				end else if (mr_rd_ok) begin
					state_d = lpis_pkg::ST_MRR;
				end else if (cmd.valid && cmd.code == lpis_pkg::CMD_MPC) begin
					state_d = lpis_pkg::ST_MPC;
				end else if (!cke) begin
					state_d = lpis_pkg::ST_SREF_PDN;
				end else if (cmd.valid && cmd.code == lpis_pkg::CMD_SRX) begin
					state_d = lpis_pkg::ST_IDLE;
				end
			end
			lpis_pkg::ST_PDN: begin
				if (cke) begin
					state_d = (banks_q != lpis_pkg::BYTE_ZERO) ? lpis_pkg::ST_ACTIVE
						: lpis_pkg::ST_IDLE;
				end
			end
			lpis_pkg::ST_SREF_PDN: begin
				if (cke) begin
					state_d = lpis_pkg::ST_SREF;
				end
			end
			lpis_pkg::ST_CBT: begin
				// only an explicit write clearing the training bit leaves
				// training may start with banks open, so idle is not assumed
				if (mr_wr_ok && reg_addr == lpis_pkg::MR13_ADDR
					&& !mr13_new[lpis_pkg::MR13_CBT_BIT]) begin
					state_d = (banks_d != lpis_pkg::BYTE_ZERO) ? lpis_pkg::ST_ACTIVE
						: lpis_pkg::ST_IDLE;
				end
			end
			lpis_pkg::ST_WLEV: begin
				if (mr_wr_ok && reg_addr == lpis_pkg::MR2_ADDR
					&& !mr2_new[lpis_pkg::MR2_WLEV_BIT]) begin
					state_d = (banks_d != lpis_pkg::BYTE_ZERO) ? lpis_pkg::ST_ACTIVE
						: lpis_pkg::ST_IDLE;
				end
			end
			default: state_d = lpis_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= lpis_pkg::ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// origin of an auto-return state, captured on entry
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ret_q <= lpis_pkg::ST_IDLE;
		end else if ((state_d == lpis_pkg::ST_MRW || state_d == lpis_pkg::ST_MRR
			|| state_d == lpis_pkg::ST_MPC) && state_d != state_q) begin
			ret_q <= (banks_d != lpis_pkg::BYTE_ZERO && state_q != lpis_pkg::ST_SREF)
				? lpis_pkg::ST_ACTIVE : state_q;
		end
	end

	// read data valid only the cycle after the read strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= lpis_pkg::BYTE_ZERO;
		end else begin
			rdata_q <= lpis_pkg::BYTE_ZERO;
			if (mr_rd_ok) begin
				for (int i = 0; i < lpis_pkg::N_MR; i++) begin
					if (reg_addr == lpis_pkg::MR_ADDRS[i] && lpis_pkg::MR_READABLE[i]) begin
						rdata_q <= mr_val[i];
					end
				end
			end
		end
	end

	// registered echo stands in for the asynchronous return path
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dq_q    <= lpis_pkg::DQ_ZERO;
			dq_oe_q <= 1'b0;
		end else if (state_q == lpis_pkg::ST_CBT && cs) begin
			dq_q    <= {10'h000, cmd.ca};
			dq_oe_q <= 1'b1;
		end else if (state_q != lpis_pkg::ST_CBT) begin
			dq_q    <= lpis_pkg::DQ_ZERO;
			dq_oe_q <= 1'b0;
		end
	end

	assign reg_rdata = rdata_q;
	assign state = state_q;
	assign banks_open = banks_q;
	assign dq_out = dq_q;
	assign dq_oe = dq_oe_q;

	// defaults come from the mode register reset values
	always_comb begin
		cfg.freq_set_point_select = mr_val[5][lpis_pkg::MR13_FSP_LSB +: 2];
		cfg.write_latency_set_bit = mr_val[1][lpis_pkg::MR2_WLS_BIT];
		cfg.wl_code = mr_val[1][lpis_pkg::MR2_WL_LSB +: 3];
		cfg.rl_code = mr_val[1][lpis_pkg::MR2_RL_LSB +: 3];
		cfg.write_recovery_cycles = mr_val[0][lpis_pkg::MR1_NWR_LSB +: 3];
		cfg.dbi_en = mr_val[2][lpis_pkg::MR3_DBI_LSB +: 2];
		cfg.ca_odt = mr_val[3][lpis_pkg::MR11_CAODT_LSB +: 3];
		cfg.dq_odt = mr_val[3][lpis_pkg::MR11_DQODT_LSB +: 3];
		cfg.vref_ca_range = mr_val[4][lpis_pkg::VREF_RANGE_BIT];
		cfg.vref_ca_value = mr_val[4][lpis_pkg::VREF_VAL_LSB +: 6];
		cfg.vref_dq_range = mr_val[6][lpis_pkg::VREF_RANGE_BIT];
		cfg.vref_dq_value = mr_val[6][lpis_pkg::VREF_VAL_LSB +: 6];
	end

endmodule

/* dv/lpis_init_sequencer_properties.sv */
// concurrent checks on the lpddr4 init sequencer ports
`timescale 1ns/1ps
module lpis_checker (
	input wire logic                  clk_sys,
	input wire logic                  rstn,
	input wire logic                  cke,
	input wire logic                  cs,
	input wire lpis_pkg::lpis_cmd_s   cmd,
	input wire logic [5:0]            reg_addr,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire lpis_pkg::lpis_state_e state,
	input wire logic [7:0]            banks_open,
	input wire logic [15:0]           dq_out,
	input wire logic                  dq_oe,
	input wire lpis_pkg::lpis_cfg_s   cfg
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence s_mrw_ret;
		state == lpis_pkg::ST_MRW ##1 state == $past(state, 2);
	endsequence
	property p_rst_state;
		disable iff (1'b0) !rstn |-> state == lpis_pkg::ST_RESET && banks_open == 8'h00 && !dq_oe;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("state not cleared by reset");
	property p_auto_ret;
		state inside {lpis_pkg::ST_IDLE, lpis_pkg::ST_ACTIVE, lpis_pkg::ST_SREF} && cke && reg_wr
			&& !cmd.valid && reg_addr == lpis_pkg::MR1_ADDR |=> s_mrw_ret;
	endproperty
	a_auto_ret: assert property (p_auto_ret) else $error("mode write did not return");
	// training only ends by an explicit mode write
	property p_train_hold;
		state inside {lpis_pkg::ST_CBT, lpis_pkg::ST_WLEV} && cke && !reg_wr && !cmd.valid
			|=> state == $past(state);
	endproperty
	a_train_hold: assert property (p_train_hold) else $error("training left on its own");
	property p_cbt_echo;
		state == lpis_pkg::ST_CBT && cs |=> dq_oe && dq_out == {10'h000, $past(cmd.ca)};
	endproperty
	a_cbt_echo: assert property (p_cbt_echo) else $error("training echo wrong");
	property p_idle_clean;
		state == lpis_pkg::ST_IDLE |-> banks_open == 8'h00;
	endproperty
	a_idle_clean: assert property (p_idle_clean) else $error("bank open in idle");
	property p_sref_pdn;
		state == lpis_pkg::ST_SREF && !cke && !reg_wr && !reg_rd && !cmd.valid
			|=> state == lpis_pkg::ST_SREF_PDN;
	endproperty
	a_sref_pdn: assert property (p_sref_pdn) else $error("no power-down from self-refresh");
	property p_def_fsp;
		$rose(rstn) |-> cfg.freq_set_point_select == 2'h0;
	endproperty
	a_def_fsp: assert property (p_def_fsp) else $error("set point default wrong");
	property p_def_lat;
		$rose(rstn) |-> {cfg.write_latency_set_bit, cfg.wl_code, cfg.rl_code,
			cfg.write_recovery_cycles} == 10'h000;
	endproperty
	a_def_lat: assert property (p_def_lat) else $error("latency default wrong");
	property p_def_term;
		$rose(rstn) |-> {cfg.dbi_en, cfg.ca_odt, cfg.dq_odt} == 8'h00 && {cfg.vref_ca_range,
			cfg.vref_ca_value, cfg.vref_dq_range, cfg.vref_dq_value} == 14'h2edd;
	endproperty
	a_def_term: assert property (p_def_term) else $error("termination default wrong");
endmodule
bind lpis_init_sequencer lpis_checker lpis_checker_i (.clk_sys, .rstn, .cke, .cs, .cmd,
	.reg_addr, .reg_wr, .reg_rd, .state, .banks_open, .dq_out, .dq_oe, .cfg);

/* dv/lpis_ctrl_model.sv */
// controller-side model: reset pin, clock enable and command bus
`timescale 1ns/1ps
module lpis_ctrl_model #(
	parameter int T_RST_LOW  = 3,
	parameter int T_CKE_POST = 8,
	parameter int T_MODE     = 50,
	parameter int T_ZQ       = 25,
	parameter int T_ZQLAT    = 80
) (
	input  wire logic           clk_sys,
	output logic                rstn,
	output logic                cke,
	output logic                cs,
	output lpis_pkg::lpis_cmd_s cmd
);
	// start high then drop, so the reset edge comes after time zero
	initial begin
		rstn = 1'b1;
		cke = 1'b0;
		cs = 1'b0;
		cmd = '0;
		#1 rstn = 1'b0;
	end
	// waits are whole cycles rounded up; reset low scaled down to keep runs short
	task automatic bring_up();
		cke <= 1'b0;
		repeat (T_RST_LOW) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (T_CKE_POST) @(posedge clk_sys);
		cs <= 1'b0;
		cke <= 1'b1;
		repeat (T_MODE) @(posedge clk_sys);
	endtask
	task automatic drop();
		@(posedge clk_sys);
		rstn <= 1'b0;
		cke <= 1'b0;
	endtask
	task automatic set_cke(input logic v);
		@(posedge clk_sys);
		cke <= v;
	endtask
	// released bus shows inverted value, never the last one
	task automatic send(input lpis_pkg::lpis_cmd_e c, input logic [2:0] b, input logic [5:0] ca);
		@(posedge clk_sys);
		cmd <= '{1'b1, c, b, ca};
		@(posedge clk_sys);
		cmd <= '{1'b0, lpis_pkg::CMD_NOP, ~b, ~ca};
	endtask
	task automatic pat(input logic [5:0] ca);
		@(posedge clk_sys);
		cs <= 1'b1;
		cmd.ca <= ca;
		@(posedge clk_sys);
		cs <= 1'b0;
		cmd.ca <= ~ca;
	endtask
	// one device on the resistor, so calibrations never overlap
	task automatic calib();
		send(lpis_pkg::CMD_MPC, 3'h0, 6'h00);
		repeat (T_ZQ) @(posedge clk_sys);
		send(lpis_pkg::CMD_MPC_DONE, 3'h0, 6'h00);
		repeat (T_ZQLAT) @(posedge clk_sys);
	endtask
endmodule

/* dv/tb_lpis_init_sequencer.sv */
// self-checking bench for the lpddr4 init sequencer
`timescale 1ns/1ps
module tb_lpis_init_sequencer;
	localparam logic [5:0] PAT_V [4] = '{6'h15, 6'h2a, 6'h3f, 6'h01};
	localparam logic [5:0] ND_A [6] = '{6'h02, 6'h03, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
	localparam logic [7:0] ND_D [6] = '{8'h7f, 8'hc0, 8'h77, 8'h12, 8'hc0, 8'h00};
	logic                  clk_sys;
	logic                  rstn;
	logic                  cke;
	logic                  cs;
	lpis_pkg::lpis_cmd_s   cmd;
	logic [5:0]            reg_addr;
	logic [7:0]            reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [7:0]            reg_rdata;
	lpis_pkg::lpis_state_e state;
	logic [7:0]            banks_open;
	logic [15:0]           dq_out;
	logic                  dq_oe;
	lpis_pkg::lpis_cfg_s   cfg;
	int                    err_total;
	int                    checked;
	lpis_init_sequencer lpis_init_sequencer_i (.clk_sys, .rstn, .cke, .cs, .cmd, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .state, .banks_open, .dq_out, .dq_oe, .cfg);
	lpis_ctrl_model lpis_ctrl_model_i (.clk_sys, .rstn, .cke, .cs, .cmd);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic st(input lpis_pkg::lpis_state_e e);
		#1 chk(16'(state), 16'(e));
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(16'(reg_rdata), 16'(exp));
	endtask
	task automatic defs();
		chk(16'(cfg.freq_set_point_select), 16'h0000);
		chk(16'({cfg.write_latency_set_bit, cfg.wl_code}), 16'h0000);
		chk(16'({cfg.rl_code, cfg.write_recovery_cycles}), 16'h0000);
		chk(16'({cfg.dbi_en, cfg.ca_odt, cfg.dq_odt}), 16'h0000);
		chk(16'({cfg.vref_ca_range, cfg.vref_ca_value, cfg.vref_dq_range,
			cfg.vref_dq_value}), 16'h2edd);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// whole run is a few hundred cycles
	initial begin
		#50000;
		err_total++;
		finish_test();
	end
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		err_total = 0;
		checked = 0;
		lpis_ctrl_model_i.bring_up();
		st(lpis_pkg::ST_IDLE);
		defs();
		rd(6'h0c, 8'h5d);
		rd(6'h0e, 8'h5d);
		wr(6'h01, 8'h70);
		st(lpis_pkg::ST_MRW);
		@(posedge clk_sys);
		st(lpis_pkg::ST_IDLE);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_ACT, 3'h2, 6'h00);
		st(lpis_pkg::ST_ACTIVE);
		chk(16'(banks_open), 16'h0004);
		wr(6'h01, 8'h30);
		st(lpis_pkg::ST_MRW);
		@(posedge clk_sys);
		st(lpis_pkg::ST_ACTIVE);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_PRE_ALL, 3'h0, 6'h00);
		st(lpis_pkg::ST_IDLE);
		chk(16'(banks_open), 16'h0000);
		lpis_ctrl_model_i.calib();
		st(lpis_pkg::ST_IDLE);
		wr(6'h0d, 8'h01);
		repeat (4) @(posedge clk_sys);
		st(lpis_pkg::ST_CBT);
		for (int i = 0; i < 4; i++) begin
			lpis_ctrl_model_i.pat(PAT_V[i]);
			#1 chk(dq_out, {10'h000, PAT_V[i]});
			chk(16'(dq_oe), 16'h0001);
		end
		wr(6'h0d, 8'h00);
		repeat (2) @(posedge clk_sys);
		st(lpis_pkg::ST_IDLE);
		chk(16'(dq_oe), 16'h0000);
		wr(6'h02, 8'h80);
		repeat (4) @(posedge clk_sys);
		st(lpis_pkg::ST_WLEV);
		wr(6'h02, 8'h00);
		repeat (2) @(posedge clk_sys);
		st(lpis_pkg::ST_IDLE);
		for (int i = 0; i < 6; i++) begin
			wr(ND_A[i], ND_D[i]);
		end
		rd(6'h0c, 8'h12);
		st(lpis_pkg::ST_MRR);
		@(posedge clk_sys);
		st(lpis_pkg::ST_IDLE);
		rd(6'h0d, 8'h00);
		chk(16'(cfg.freq_set_point_select), 16'h0003);
		chk(16'({cfg.write_latency_set_bit, cfg.wl_code}), 16'h000f);
		chk(16'({cfg.rl_code, cfg.write_recovery_cycles}), 16'h003b);
		chk(16'({cfg.dbi_en, cfg.ca_odt, cfg.dq_odt}), 16'h00ff);
		chk(16'({cfg.vref_ca_range, cfg.vref_ca_value, cfg.vref_dq_range,
			cfg.vref_dq_value}), 16'h0900);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_SRE, 3'h0, 6'h00);
		st(lpis_pkg::ST_SREF);
		wr(6'h01, 8'h00);
		st(lpis_pkg::ST_MRW);
		@(posedge clk_sys);
		st(lpis_pkg::ST_SREF);
		rd(6'h0c, 8'h12);
		st(lpis_pkg::ST_MRR);
		@(posedge clk_sys);
		st(lpis_pkg::ST_SREF);
		lpis_ctrl_model_i.set_cke(1'b0);
		@(posedge clk_sys);
		st(lpis_pkg::ST_SREF_PDN);
		lpis_ctrl_model_i.set_cke(1'b1);
		@(posedge clk_sys);
		st(lpis_pkg::ST_SREF);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_SRX, 3'h0, 6'h00);
		st(lpis_pkg::ST_IDLE);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_ACT, 3'h5, 6'h00);
		lpis_ctrl_model_i.set_cke(1'b0);
		@(posedge clk_sys);
		st(lpis_pkg::ST_PDN);
		lpis_ctrl_model_i.set_cke(1'b1);
		@(posedge clk_sys);
		st(lpis_pkg::ST_ACTIVE);
		chk(16'(banks_open), 16'h0020);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_PRE, 3'h5, 6'h00);
		st(lpis_pkg::ST_IDLE);
		lpis_ctrl_model_i.send(lpis_pkg::CMD_ACT, 3'h1, 6'h00);
		lpis_ctrl_model_i.drop();
		st(lpis_pkg::ST_RESET);
		chk(16'(banks_open), 16'h0000);
		defs();
		lpis_ctrl_model_i.bring_up();
		st(lpis_pkg::ST_IDLE);
		finish_test();
	end
endmodule
